// >>> hw/mcr_lab.sv
// logic array block: sixteen macrocells, shared terms and apb configuration
`timescale 1ns/1ps
// Notes on behaviour
// - each macrocell register runs as D, T, JK or SR type, own clocking
// - any macrocell may bypass its register and output its combinational sum
// - clocking per register: global clock, gated global clock, or term clock
// - gated mode captures only on global edges with its enable term high
// - array clock comes from a term over feedback and pin signals
// - two global networks, each true or inverted level of either clock pin
// - term-driven preset and clear, active high, act asynchronously
// - per register option: active-low global clear pin drives the clear
// - every macrocell register is cleared at power-up, outputs low
// - each macrocell has five product terms of its own
// - sixteen shareable terms, one per macrocell, inverted back into array
// - any shareable term may feed any number of macrocells at once
// - parallel expander terms add to any macrocell of the block
module mcr_lab (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clkEn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic global_clock_pin_a,
    input wire logic global_clock_pin_b,
    input wire logic global_clear_low,
    input wire logic [15:0] ioPins,
    output logic [15:0] mcOut
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [mcr_pkg::ARR_W-1:0] tMask_reg [mcr_pkg::NUM_PT];
    logic [mcr_pkg::ARR_W-1:0] cMask_reg [mcr_pkg::NUM_PT];
    logic [31:0] cfgA_reg [mcr_pkg::NUM_MC];
    logic [31:0] cfgB_reg [mcr_pkg::NUM_MC];
    logic [6:0] ptIdx_reg;
    logic [3:0] gnet_reg;
    logic [18:0] sync1_reg;
    logic [18:0] sync2_reg;
    logic [1:0] netPrev_reg;
    logic [15:0] exp_reg;
    logic rdy_reg;
    logic err_reg;
    logic [31:0] rdata_reg;

    // ------------------------------------------------------------
    // combinational nets
    // ------------------------------------------------------------
    logic [mcr_pkg::ARR_W-1:0] arr;
    logic [mcr_pkg::NUM_PT-1:0] ptVal;
    logic [15:0] parV;
    logic [15:0] pinS;
    logic gA;
    logic gB;
    logic gclrLow;
    logic [1:0] netLvl;
    logic [1:0] netRise;
    logic access;
    logic wrEn;
    logic idxOk;
    logic hit;
    logic [31:0] rdVal;
    logic [3:0] mcSel;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_reg <= mcr_pkg::SYNC_RST;
            sync2_reg <= mcr_pkg::SYNC_RST;
        end else if (clkEn) begin
            sync1_reg <= {global_clear_low, global_clock_pin_b, global_clock_pin_a, ioPins};
            sync2_reg <= sync1_reg;
        end
    end

    assign pinS = sync2_reg[15:0];
    assign gA = sync2_reg[16];
    assign gB = sync2_reg[17];
    assign gclrLow = sync2_reg[18];

    // ------------------------------------------------------------
    // global clock networks
    // ------------------------------------------------------------
    // edges are seen on the sampled pin level, so pins must be slower than core_clk
    assign netLvl[0] = (gnet_reg[mcr_pkg::G0_PIN] ? gB : gA) ^ gnet_reg[mcr_pkg::G0_INV];
    assign netLvl[1] = (gnet_reg[mcr_pkg::G1_PIN] ? gB : gA) ^ gnet_reg[mcr_pkg::G1_INV];
    assign netRise = netLvl & ~netPrev_reg;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            netPrev_reg <= 2'h0;
        end else if (clkEn) begin
            netPrev_reg <= netLvl;
        end
    end

    // ------------------------------------------------------------
    // logic array and product terms
    // ------------------------------------------------------------
    // feedback and expanders are registered to keep the array free of loops
    assign arr = {exp_reg, mcOut, pinS};

    for (genvar i = 0; i < mcr_pkg::NUM_PT; i++) begin : g_pt
        assign ptVal[i] = ((tMask_reg[i] | cMask_reg[i]) != '0)
            && (&(arr | ~tMask_reg[i]))
            && (&(~arr | ~cMask_reg[i]));
    end

    // ------------------------------------------------------------
    // shareable expanders
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            exp_reg <= 16'h0000;
        end else if (clkEn) begin
            for (int m = 0; m < mcr_pkg::NUM_MC; m++) begin
                exp_reg[m] <= ~ptVal[m * mcr_pkg::SLOTS + mcr_pkg::PT_PER_MC];
            end
        end
    end

    // ------------------------------------------------------------
    // macrocells and parallel expanders
    // ------------------------------------------------------------
    for (genvar m = 0; m < mcr_pkg::NUM_MC; m++) begin : g_mc
        logic [3:0] src;
        logic [4:0] srcPt;

        assign src = cfgB_reg[m][mcr_pkg::F_PSRC +: 4];
        assign srcPt = ptVal[src * mcr_pkg::SLOTS +: mcr_pkg::PT_PER_MC];
        assign parV[m] = |(srcPt & cfgB_reg[m][mcr_pkg::F_PMASK +: 5]);

        mcr_macrocell u_mc (
            .core_clk(core_clk),
            .arst_n(arst_n),
            .clkEn(clkEn),
            .pt(ptVal[m * mcr_pkg::SLOTS +: mcr_pkg::PT_PER_MC]),
            .parTerm(parV[m]),
            .cfg(cfgA_reg[m]),
            .netRise(netRise),
            .gclrLow(gclrLow),
            .qOut(mcOut[m])
        );
    end

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    assign access = psel & penable;
    assign wrEn = access & rdy_reg & pwrite & hit;
    assign idxOk = ptIdx_reg < 7'(mcr_pkg::NUM_PT);
    assign mcSel = paddr[5:2];
    assign pready = rdy_reg;
    assign pslverr = err_reg;
    assign prdata = rdata_reg;

    always_comb begin
        hit = (paddr[1:0] == 2'h0);
        rdVal = 32'h0000_0000;
        if (paddr[7:6] == mcr_pkg::PAGE_CFGA) begin
            rdVal = cfgA_reg[mcSel];
        end else if (paddr[7:6] == mcr_pkg::PAGE_CFGB) begin
            rdVal = cfgB_reg[mcSel];
        end else if (paddr == mcr_pkg::A_PT_IDX) begin
            rdVal = {25'h000_0000, ptIdx_reg};
        end else if (paddr == mcr_pkg::A_T_LO) begin
            rdVal = idxOk ? tMask_reg[ptIdx_reg][31:0] : 32'h0000_0000;
        end else if (paddr == mcr_pkg::A_T_HI) begin
            rdVal = idxOk ? {16'h0000, tMask_reg[ptIdx_reg][47:32]} : 32'h0000_0000;
        end else if (paddr == mcr_pkg::A_C_LO) begin
            rdVal = idxOk ? cMask_reg[ptIdx_reg][31:0] : 32'h0000_0000;
        end else if (paddr == mcr_pkg::A_C_HI) begin
            rdVal = idxOk ? {16'h0000, cMask_reg[ptIdx_reg][47:32]} : 32'h0000_0000;
        end else if (paddr == mcr_pkg::A_GNET) begin
            rdVal = {28'h000_0000, gnet_reg};
        end else if (paddr == mcr_pkg::A_STAT) begin
            rdVal = {16'h0000, mcOut};
        end else if (paddr == mcr_pkg::A_PINS) begin
            rdVal = {13'h0000, sync2_reg};
        end else begin
            hit = 1'b0;
        end
    end

    // one wait state: ready rises in the second access cycle
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdy_reg <= 1'b0;
            err_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else if (clkEn) begin
            rdy_reg <= access & ~rdy_reg;
            if (access && !rdy_reg) begin
                err_reg <= ~hit;
                rdata_reg <= (pwrite || !hit) ? 32'h0000_0000 : rdVal;
            end else begin
                err_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ptIdx_reg <= 7'h00;
            gnet_reg <= mcr_pkg::GNET_RST;
        end else if (clkEn && wrEn) begin
            if (paddr == mcr_pkg::A_PT_IDX) begin
                ptIdx_reg <= pwdata[6:0];
            end
            if (paddr == mcr_pkg::A_GNET) begin
                gnet_reg <= pwdata[3:0];
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int m = 0; m < mcr_pkg::NUM_MC; m++) begin
                cfgA_reg[m] <= mcr_pkg::CFGA_RST;
                cfgB_reg[m] <= mcr_pkg::CFGB_RST;
            end
        end else if (clkEn && wrEn) begin
            if (paddr[7:6] == mcr_pkg::PAGE_CFGA) begin
                cfgA_reg[mcSel] <= pwdata;
            end
            if (paddr[7:6] == mcr_pkg::PAGE_CFGB) begin
                cfgB_reg[mcSel] <= pwdata;
            end
        end
    end

    // ------------------------------------------------------------
    // product term masks
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < mcr_pkg::NUM_PT; i++) begin
                tMask_reg[i] <= '0;
                cMask_reg[i] <= '0;
            end
        end else if (clkEn && wrEn && idxOk) begin
            if (paddr == mcr_pkg::A_T_LO) begin
                tMask_reg[ptIdx_reg][31:0] <= pwdata;
            end
            if (paddr == mcr_pkg::A_T_HI) begin
                tMask_reg[ptIdx_reg][47:32] <= pwdata[15:0];
            end
            if (paddr == mcr_pkg::A_C_LO) begin
                cMask_reg[ptIdx_reg][31:0] <= pwdata;
            end
            if (paddr == mcr_pkg::A_C_HI) begin
                cMask_reg[ptIdx_reg][47:32] <= pwdata[15:0];
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_PWRUP: assert property (@(posedge core_clk) disable iff (!arst_n)
        !$past(arst_n) |-> (mcOut == 16'h0000) && !pready) else $error("outputs not low after reset");

    AST_APB_WAIT: assert property (@(posedge core_clk) disable iff (!arst_n)
        clkEn && access && !rdy_reg |=> rdy_reg) else $error("apb ready not raised");

    AST_EXPANDER: assert property (@(posedge core_clk) disable iff (!arst_n)
        clkEn && arst_n |=> exp_reg[0] == !$past(ptVal[mcr_pkg::PT_PER_MC]))
        else $error("shareable term not inverted into array");

    AST_NET0: assert property (@(posedge core_clk) disable iff (!arst_n)
        clkEn && $past(clkEn) && $stable(gnet_reg) && gnet_reg[1:0] == 2'h3 && $fell(gB) |-> netRise[0])
        else $error("inverted network missed falling pin edge");

    AST_GCLR: assert property (@(posedge core_clk) disable iff (!arst_n)
        clkEn && !gclrLow && cfgA_reg[5][mcr_pkg::F_GCLR] && !cfgA_reg[5][mcr_pkg::F_BYP] |=> !mcOut[5])
        else $error("global clear did not clear register");

    AST_IDX_WRITE: assert property (@(posedge core_clk) disable iff (!arst_n)
        clkEn && wrEn && paddr == mcr_pkg::A_PT_IDX |=> ptIdx_reg == $past(pwdata[6:0]))
        else $error("term index write lost");
endmodule

// >>> hw/mcr_pkg.sv
// constants and types for the macrocell logic array block
package mcr_pkg;
    localparam int NUM_MC = 16;
    localparam int PT_PER_MC = 5;
    localparam int SLOTS = 6;
    localparam int NUM_PT = 96;
    localparam int PIN_W = 16;
    localparam int ARR_W = 48;
    localparam logic [7:0] A_PT_IDX = 8'h00;
    localparam logic [7:0] A_T_LO = 8'h04;
    localparam logic [7:0] A_T_HI = 8'h08;
    localparam logic [7:0] A_C_LO = 8'h0C;
    localparam logic [7:0] A_C_HI = 8'h10;
    localparam logic [7:0] A_GNET = 8'h14;
    localparam logic [7:0] A_STAT = 8'h18;
    localparam logic [7:0] A_PINS = 8'h1C;
    localparam logic [1:0] PAGE_CFGA = 2'h1;
    localparam logic [1:0] PAGE_CFGB = 2'h2;
    localparam int F_TYPE = 0;
    localparam int F_BYP = 2;
    localparam int F_MODE = 3;
    localparam int F_NET = 5;
    localparam int F_CTRL = 6;
    localparam int F_PRE = 9;
    localparam int F_CLR = 12;
    localparam int F_GCLR = 15;
    localparam int F_SUM = 16;
    localparam int F_SEC = 21;
    localparam int F_PSRC = 0;
    localparam int F_PMASK = 4;
    localparam int G0_PIN = 0;
    localparam int G0_INV = 1;
    localparam int G1_PIN = 2;
    localparam int G1_INV = 3;
    localparam logic [31:0] CFGA_RST = 32'h0000_7FC0;
    localparam logic [31:0] CFGB_RST = 32'h0000_0000;
    localparam logic [3:0] GNET_RST = 4'h4;
    localparam logic [18:0] SYNC_RST = 19'h4_0000;
    localparam logic [2:0] NO_TERM = 3'h5;
    typedef enum logic [1:0] {FF_D = 2'b00, FF_T = 2'b01, FF_JK = 2'b10, FF_SR = 2'b11} mcr_ff_e;
    typedef enum logic [1:0] {CK_GLOBAL = 2'b00, CK_GATED = 2'b01, CK_ARRAY = 2'b10} mcr_ck_e;
endpackage

// >>> hw/mcr_macrocell.sv
// one macrocell: term sum, programmable flipflop, clocking and async controls
`timescale 1ns/1ps
module mcr_macrocell (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clkEn,
    input wire logic [4:0] pt,
    input wire logic parTerm,
    input wire logic [31:0] cfg,
    input wire logic [1:0] netRise,
    input wire logic gclrLow,
    output logic qOut
);
    logic q_reg;
    logic q_next;
    logic ctrlPrev_reg;
    logic sumV;
    logic secV;
    logic ctrlV;
    logic preV;
    logic clrAll;
    logic clkEvt;
    logic [2:0] ctrlIdx;
    logic [2:0] preIdx;
    logic [2:0] clrIdx;
    mcr_pkg::mcr_ff_e ffType;
    mcr_pkg::mcr_ck_e ckMode;

    assign ffType = mcr_pkg::mcr_ff_e'(cfg[mcr_pkg::F_TYPE +: 2]);
    assign ckMode = mcr_pkg::mcr_ck_e'(cfg[mcr_pkg::F_MODE +: 2]);
    assign ctrlIdx = cfg[mcr_pkg::F_CTRL +: 3];
    assign preIdx = cfg[mcr_pkg::F_PRE +: 3];
    assign clrIdx = cfg[mcr_pkg::F_CLR +: 3];
    // five own terms plus parallel expander terms
    assign sumV = (|(pt & cfg[mcr_pkg::F_SUM +: 5])) | parTerm;
    assign secV = |(pt & cfg[mcr_pkg::F_SEC +: 5]);
    assign ctrlV = (ctrlIdx < mcr_pkg::NO_TERM) ? pt[ctrlIdx] : 1'b0;
    assign preV = (preIdx < mcr_pkg::NO_TERM) ? pt[preIdx] : 1'b0;
    assign clrAll = ((clrIdx < mcr_pkg::NO_TERM) ? pt[clrIdx] : 1'b0) | (cfg[mcr_pkg::F_GCLR] & ~gclrLow);

    always_comb begin
        unique case (ckMode)
            mcr_pkg::CK_GLOBAL: clkEvt = netRise[cfg[mcr_pkg::F_NET]];
            mcr_pkg::CK_GATED: clkEvt = netRise[cfg[mcr_pkg::F_NET]] & ctrlV;
            mcr_pkg::CK_ARRAY: clkEvt = ctrlV & ~ctrlPrev_reg;
            default: clkEvt = 1'b0;
        endcase
    end

    always_comb begin
        q_next = q_reg;
        if (clrAll) begin
            q_next = 1'b0;
        end else if (preV) begin
            q_next = 1'b1;
        end else if (clkEvt) begin
            unique case (ffType)
                mcr_pkg::FF_D: q_next = sumV;
                mcr_pkg::FF_T: q_next = q_reg ^ sumV;
                mcr_pkg::FF_JK: q_next = (sumV & ~q_reg) | (~secV & q_reg);
                mcr_pkg::FF_SR: q_next = sumV | (~secV & q_reg);
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            q_reg <= 1'b0;
            ctrlPrev_reg <= 1'b0;
            qOut <= 1'b0;
        end else if (clkEn) begin
            q_reg <= q_next;
            ctrlPrev_reg <= ctrlV;
            qOut <= cfg[mcr_pkg::F_BYP] ? sumV : q_next;
        end
    end

    AST_CLR_WINS: assert property (@(posedge core_clk) disable iff (!arst_n)
        clkEn && clrAll && preV |=> !q_reg) else $error("clear did not win over preset");
    AST_PRESET: assert property (@(posedge core_clk) disable iff (!arst_n)
        clkEn && preV && !clrAll |=> q_reg) else $error("preset term did not set register");
    AST_GATED_HOLD: assert property (@(posedge core_clk) disable iff (!arst_n)
        clkEn && ckMode == mcr_pkg::CK_GATED && !ctrlV && !preV && !clrAll |=> q_reg == $past(q_reg))
        else $error("gated register changed without enable");
    AST_DTYPE: assert property (@(posedge core_clk) disable iff (!arst_n)
        clkEn && ffType == mcr_pkg::FF_D && clkEvt && !preV && !clrAll |=> q_reg == $past(sumV))
        else $error("d register did not capture sum");
    AST_BYPASS: assert property (@(posedge core_clk) disable iff (!arst_n)
        clkEn && cfg[mcr_pkg::F_BYP] |=> qOut == $past(sumV)) else $error("bypass output not combinational sum");
endmodule

// >>> verification/mcr_lab_bench.sv
// self-checking testbench for the macrocell logic array block
`timescale 1ns/1ps
module mcr_lab_bench;
// ----------------------------------------
// stimulus and observed signals
// ----------------------------------------
logic core_clk = 1'b0;
logic arst_n = 1'b0;
logic clkEn = 1'b1;
logic [7:0] paddr = 8'h00;
logic psel = 1'b0;
logic penable = 1'b0;
logic pwrite = 1'b0;
logic [31:0] pwdata = 32'h0000_0000;
logic [31:0] prdata;
logic pready;
logic pslverr;
logic gclkA = 1'b0;
logic gclkB = 1'b0;
logic gclrLow = 1'b1;
logic [15:0] ioPins = 16'h0000;
logic [15:0] mcOut;
logic [31:0] rd;
logic er;
int failures = 0;
int n_checks = 0;

always #50 core_clk = ~core_clk;

mcr_lab u_dut (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .clkEn(clkEn),
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .global_clock_pin_a(gclkA),
    .global_clock_pin_b(gclkB),
    .global_clear_low(gclrLow),
    .ioPins(ioPins),
    .mcOut(mcOut)
);

// ----------------------------------------
// shared tasks
// ----------------------------------------
task automatic print_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
        $display("== PASSED ==");
    end else begin
        $display("== FAILED ==");
    end
    $finish;
endtask

task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
        failures++;
        $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
endtask

// one apb transfer; request held until pready is sampled high
task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n = 0;
    @(posedge core_clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
        @(posedge core_clk);
        n++;
    end while (pready !== 1'b1);
    // one wait state: ready in the second access cycle
    chk(32'(n), 32'h0000_0002);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
endtask

task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
endtask

task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0000_0000);
    chk(rd, exp);
endtask

task automatic term(input int idx, input logic [47:0] t, input logic [47:0] c);
    wr(mcr_pkg::A_PT_IDX, 32'(idx));
    wr(mcr_pkg::A_T_LO, t[31:0]);
    wr(mcr_pkg::A_T_HI, {16'h0000, t[47:32]});
    wr(mcr_pkg::A_C_LO, c[31:0]);
    wr(mcr_pkg::A_C_HI, {16'h0000, c[47:32]});
endtask

function automatic logic [31:0] cfgw(input logic [1:0] ty, input logic byp, input logic [1:0] md,
    input logic [2:0] ctl, input logic [2:0] pre, input logic [2:0] clr, input logic gc,
    input logic [4:0] sm, input logic [4:0] sc);
    cfgw = (32'(ty) << mcr_pkg::F_TYPE) | (32'(byp) << mcr_pkg::F_BYP) | (32'(md) << mcr_pkg::F_MODE)
        | (32'(ctl) << mcr_pkg::F_CTRL) | (32'(pre) << mcr_pkg::F_PRE) | (32'(clr) << mcr_pkg::F_CLR)
        | (32'(gc) << mcr_pkg::F_GCLR) | (32'(sm) << mcr_pkg::F_SUM) | (32'(sc) << mcr_pkg::F_SEC);
endfunction

// pins pass two sync stages plus the register edge, so six cycles settle
task automatic pin(input int which, input logic v);
    @(posedge core_clk);
    case (which)
        0: gclkA <= v;
        1: gclkB <= v;
        2: gclrLow <= v;
        default: ioPins[which - 3] <= v;
    endcase
    repeat (6) @(posedge core_clk);
endtask

task automatic io(input int b, input logic v);
    pin(b + 3, v);
endtask

task automatic pulseA();
    pin(0, 1'b1);
    pin(0, 1'b0);
endtask

task automatic mc(input int m, input logic exp);
    chk({31'h0, mcOut[m]}, {31'h0, exp});
endtask

// ----------------------------------------
// scenarios
// ----------------------------------------
task automatic t_regs();
    rdc(8'h40, mcr_pkg::CFGA_RST);
    rdc(8'h80, mcr_pkg::CFGB_RST);
    rdc(mcr_pkg::A_GNET, {28'h0, mcr_pkg::GNET_RST});
    rdc(mcr_pkg::A_STAT, 32'h0000_0000);
    wr(mcr_pkg::A_PT_IDX, 32'h0000_0005);
    wr(mcr_pkg::A_T_LO, 32'hA5A5_0001);
    rdc(mcr_pkg::A_T_LO, 32'hA5A5_0001);
    wr(mcr_pkg::A_T_LO, 32'h0000_0000);
    wr(mcr_pkg::A_PT_IDX, 32'h0000_0060);
    wr(mcr_pkg::A_T_LO, 32'h0000_000F);
    rdc(mcr_pkg::A_T_LO, 32'h0000_0000);
    wr(mcr_pkg::A_STAT, 32'h0000_FFFF);
    rdc(mcr_pkg::A_STAT, 32'h0000_0000);
    apb(8'h30, 1'b1, 32'h0000_0001);
    chk({31'h0, er}, 32'h1);
    apb(8'h42, 1'b0, 32'h0000_0000);
    chk({31'h0, er}, 32'h1);
endtask

task automatic t_global();
    term(0, 48'h1, 48'h0);
    wr(8'h40, cfgw(mcr_pkg::FF_D, 1'b0, mcr_pkg::CK_GLOBAL, 3'h5, 3'h5, 3'h5, 1'b0, 5'h01, 5'h00));
    io(0, 1'b1);
    pulseA();
    mc(0, 1'b1);
    io(0, 1'b0);
    pin(1, 1'b1);
    pin(1, 1'b0);
    mc(0, 1'b1);
    pulseA();
    mc(0, 1'b0);
    // net0 now the inverted level of pin b
    wr(mcr_pkg::A_GNET, 32'h0000_0007);
    io(0, 1'b1);
    pin(1, 1'b1);
    mc(0, 1'b0);
    pin(1, 1'b0);
    mc(0, 1'b1);
    wr(mcr_pkg::A_GNET, 32'h0000_0004);
endtask

task automatic t_gated_array();
    term(6, 48'h1, 48'h0);
    term(7, 48'h2, 48'h0);
    wr(8'h44, cfgw(mcr_pkg::FF_D, 1'b0, mcr_pkg::CK_GATED, 3'h1, 3'h5, 3'h5, 1'b0, 5'h01, 5'h00));
    term(12, 48'h1, 48'h0);
    term(13, 48'h4, 48'h0);
    wr(8'h48, cfgw(mcr_pkg::FF_D, 1'b0, mcr_pkg::CK_ARRAY, 3'h1, 3'h5, 3'h5, 1'b0, 5'h01, 5'h00));
    pulseA();
    mc(1, 1'b0);
    mc(2, 1'b0);
    io(1, 1'b1);
    pulseA();
    mc(1, 1'b1);
    io(2, 1'b1);
    mc(2, 1'b1);
    io(2, 1'b0);
endtask

task automatic t_toggle_async();
    term(18, 48'h1, 48'h0);
    wr(8'h4C, cfgw(mcr_pkg::FF_T, 1'b0, mcr_pkg::CK_GLOBAL, 3'h5, 3'h5, 3'h5, 1'b0, 5'h01, 5'h00));
    pulseA();
    mc(3, 1'b1);
    pulseA();
    mc(3, 1'b0);
    // clock enable low freezes the register across a whole pin pulse
    @(posedge core_clk);
    clkEn <= 1'b0;
    pulseA();
    mc(3, 1'b0);
    @(posedge core_clk);
    clkEn <= 1'b1;
    term(26, 48'h8, 48'h0);
    term(27, 48'h10, 48'h0);
    wr(8'h50, cfgw(mcr_pkg::FF_D, 1'b0, mcr_pkg::CK_GLOBAL, 3'h5, 3'h2, 3'h3, 1'b0, 5'h00, 5'h00));
    io(3, 1'b1);
    mc(4, 1'b1);
    io(4, 1'b1);
    mc(4, 1'b0);
    io(3, 1'b0);
    io(4, 1'b0);
    mc(4, 1'b0);
    term(30, 48'h1, 48'h0);
    wr(8'h54, cfgw(mcr_pkg::FF_D, 1'b0, mcr_pkg::CK_GLOBAL, 3'h5, 3'h5, 3'h5, 1'b1, 5'h01, 5'h00));
    pulseA();
    mc(5, 1'b1);
    pin(2, 1'b0);
    mc(5, 1'b0);
    mc(0, 1'b1);
    pin(2, 1'b1);
    pulseA();
    mc(5, 1'b1);
endtask

task automatic t_expanders();
    term(36, 48'h80, 48'h0);
    wr(8'h58, cfgw(mcr_pkg::FF_D, 1'b1, mcr_pkg::CK_GLOBAL, 3'h5, 3'h5, 3'h5, 1'b0, 5'h01, 5'h00));
    io(7, 1'b1);
    mc(6, 1'b1);
    io(7, 1'b0);
    mc(6, 1'b0);
    // shareable term of macrocell 7 used by macrocells 8 and 9 at once
    term(47, 48'h100, 48'h0);
    term(48, 48'h0, 48'h0080_0000_0000);
    term(54, 48'h0, 48'h0080_0000_0000);
    wr(8'h60, cfgw(mcr_pkg::FF_D, 1'b1, mcr_pkg::CK_GLOBAL, 3'h5, 3'h5, 3'h5, 1'b0, 5'h01, 5'h00));
    wr(8'h64, cfgw(mcr_pkg::FF_D, 1'b1, mcr_pkg::CK_GLOBAL, 3'h5, 3'h5, 3'h5, 1'b0, 5'h01, 5'h00));
    io(8, 1'b1);
    mc(8, 1'b1);
    mc(9, 1'b1);
    io(8, 1'b0);
    mc(8, 1'b0);
    mc(9, 1'b0);
    term(66, 48'h200, 48'h0);
    wr(8'h68, cfgw(mcr_pkg::FF_D, 1'b1, mcr_pkg::CK_GLOBAL, 3'h5, 3'h5, 3'h5, 1'b0, 5'h00, 5'h00));
    wr(8'hA8, 32'h0000_001B);
    io(9, 1'b1);
    mc(10, 1'b1);
    io(9, 1'b0);
    mc(10, 1'b0);
endtask

task automatic t_jk_sr();
    term(72, 48'h400, 48'h0);
    term(73, 48'h800, 48'h0);
    term(78, 48'h400, 48'h0);
    term(79, 48'h800, 48'h0);
    wr(8'h70, cfgw(mcr_pkg::FF_SR, 1'b0, mcr_pkg::CK_GLOBAL, 3'h5, 3'h5, 3'h5, 1'b0, 5'h01, 5'h02));
    wr(8'h74, cfgw(mcr_pkg::FF_JK, 1'b0, mcr_pkg::CK_GLOBAL, 3'h5, 3'h5, 3'h5, 1'b0, 5'h01, 5'h02));
    io(10, 1'b1);
    pulseA();
    mc(12, 1'b1);
    mc(13, 1'b1);
    io(11, 1'b1);
    pulseA();
    mc(12, 1'b1);
    mc(13, 1'b0);
    io(10, 1'b0);
    pulseA();
    mc(12, 1'b0);
    mc(13, 1'b0);
endtask

// ----------------------------------------
// main sequence and watchdog
// ----------------------------------------
initial begin
    repeat (2) @(posedge core_clk);
    chk({16'h0, mcOut}, 32'h0000_0000);
    arst_n <= 1'b1;
    @(posedge core_clk);
    t_regs();
    t_global();
    t_gated_array();
    t_toggle_async();
    t_expanders();
    t_jk_sr();
    print_verdict();
end

initial begin
    #3_000_000;
    failures++;
    print_verdict();
end

endmodule
